// >>> opd_pkg.sv
/*
 package for the operand decoder: instruction word layout, operand
 encodings, decoded operand carriers.
 assumes one 125 MHz core clock shared by fetch, decoder and datapath.
*/
package opd_pkg;
    localparam int INSN_W = 24;
    localparam int TYPE_W = 8;
    localparam int TYPE_LSB = 16;
    localparam logic [7:0] SECOND_WORD_TYPE = 8'h00;
    localparam logic [7:0] NOP_TYPE = 8'h00;
    localparam int FILE_ADDR_W = 13;
    localparam logic [12:0] FILE_ADDR_MAX = 13'h1FFF;
    localparam logic [9:0] BYTE_LIT_MAX = 10'h0FF;
    localparam logic [3:0] REG_W0 = 4'h0;
    localparam logic [3:0] REG_W4 = 4'h4;
    localparam logic [3:0] REG_W8 = 4'h8;
    localparam logic [3:0] REG_W9 = 4'h9;
    localparam logic [3:0] REG_W10 = 4'hA;
    localparam logic [3:0] REG_W11 = 4'hB;
    localparam logic [3:0] REG_W12 = 4'hC;
    localparam logic [3:0] REG_W13 = 4'hD;
    localparam logic [4:0] WB_POST_INC = 5'h02;
    localparam int ACC_W = 40;

    // field positions inside the 16-bit operand part
    localparam int SRC_REG_LSB = 0;
    localparam int SRC_MODE_LSB = 4;
    localparam int DST_REG_LSB = 7;
    localparam int DST_MODE_LSB = 11;
    localparam int BASE_REG_LSB = 11;
    localparam int BIT_INDEX_LSB = 12;
    localparam int ACC_SEL_BIT = 15;
    localparam int WIDTH_LSB = 14;
    localparam int SHADOW_BIT = 13;
    localparam int MUL_PAIR_LSB = 0;
    localparam int X_PF_LSB = 2;
    localparam int Y_PF_LSB = 6;
    localparam int XD_LSB = 10;
    localparam int YD_LSB = 12;
    localparam int WB_DEST_BIT = 14;
    localparam int WB_EN_BIT = 13;

    typedef enum logic [2:0] {
        OPD_AM_DIRECT,
        OPD_AM_INDIRECT,
        OPD_AM_POST_INC,
        OPD_AM_POST_DEC,
        OPD_AM_PRE_INC,
        OPD_AM_PRE_DEC,
        OPD_AM_INDEXED,
        OPD_AM_BAD
    } opd_amode_e;

    typedef enum logic [1:0] {
        OPD_SZ_WORD,
        OPD_SZ_BYTE,
        OPD_SZ_DWORD,
        OPD_SZ_BAD
    } opd_size_e;

    typedef enum logic [1:0] {
        OPD_WB_NONE,
        OPD_WB_DIRECT,
        OPD_WB_POST_INC2
    } opd_wb_e;

    typedef struct packed {
        logic valid;
        logic [3:0] reg_sel;
        logic [3:0] base_sel;
        opd_amode_e mode;
    } opd_waddr_s;

    typedef struct packed {
        logic valid;
        logic [3:0] reg_sel;
        logic signed [3:0] post_mod;
        logic use_offset;
        logic [3:0] dest_sel;
    } opd_prefetch_s;

    typedef struct packed {
        logic acc_sel_b;
        logic [3:0] mul_a;
        logic [3:0] mul_b;
        logic mul_ok;
        opd_wb_e wb_kind;
        logic [3:0] wb_reg;
        logic signed [4:0] wb_post_mod;
    } opd_dsp_s;

    typedef struct packed {
        logic c;
        logic dc;
        logic n;
        logic ov;
        logic z;
    } opd_cpu_flags_s;

    typedef struct packed {
        logic oa;
        logic ob;
        logic sa;
        logic sb;
    } opd_dsp_flags_s;
endpackage

// >>> opd_prefetch_decode.sv
/*
 decodes one 4-bit DSP prefetch address field plus its 2-bit
 destination field into a prefetch descriptor.
 assumes the caller picks the register pair of its data space.
*/
`timescale 1ns/1ps
module opd_prefetch_decode (
    input wire logic [3:0] code_i,
    input wire logic [1:0] dest_i,
    input wire logic [3:0] reg_lo_i,
    input wire logic [3:0] reg_hi_i,
    output opd_pkg::opd_prefetch_s pf_o
);
    always_comb begin
        pf_o = '0;
        pf_o.dest_sel = opd_pkg::REG_W4 + {2'h0, dest_i};
        // codes 0..6 low reg, 7..13 high reg, 14 offset form, 15 none
        if (code_i < 4'hE) begin
            pf_o.valid = 1'b1;
            pf_o.reg_sel = (code_i < 4'h7) ? reg_lo_i : reg_hi_i;
            case ((code_i < 4'h7) ? code_i : code_i - 4'h7)
                4'h0: pf_o.post_mod = 4'sh0;
                4'h1: pf_o.post_mod = 4'sh2;
                4'h2: pf_o.post_mod = 4'sh4;
                4'h3: pf_o.post_mod = 4'sh6;
                4'h4: pf_o.post_mod = -4'sh2;
                4'h5: pf_o.post_mod = -4'sh4;
                default: pf_o.post_mod = -4'sh6;
            endcase
        end else if (code_i == 4'hE) begin
            pf_o.valid = 1'b1;
            pf_o.reg_sel = reg_hi_i;
            pf_o.use_offset = 1'b1;
        end
    end
endmodule // opd_prefetch_decode

// >>> opd_operand_decode.sv
/*
 operand decoder: registers one instruction word from fetch and
 presents decoded operand fields to the datapath; keeps the cpu and
 dsp status flags that the datapath reports.
 assumes fetch gives one word per valid pulse and marks second words.
*/
// Behaviour
// - word is 24 bits; top 8 bits give instruction type.
// - second word of a two-word instruction, executed alone, is a nop.
// - accumulator operand picks one of two 40-bit accumulators, a or b.
// - write-back is w13 direct or [w13] then w13 plus 2.
// - bit index is 4 bits, picking bit 0..15 of the word.
// - keep carry, half carry, negative, overflow and zero flags.
// - keep overflow and clip flags for both accumulators.
// - file register address spans 0x0000..0x1FFF.
// - ten-bit literal limited to 255 in byte mode, 1023 in word mode.
// - program address literal is 23 bits with lsb zero.
// - unsigned literals of 1,4,5,8,14,16 bits span their full width.
// - 6, 10, 16 bit signed literals are two's complement.
// - base, source and destination fields pick any of w0..w15.
// - six forms: direct, indirect, pre/post increment or decrement.
// - dsp source/destination also allow register plus base indirect.
// - file register ops use w0 as implied operand and alternate dest.
// - divide takes dividend and divisor from two direct registers.
// - square accepts only w4..w7 each with itself.
// - dsp multiply accepts only the six distinct pairs from w4..w7.
// - x prefetch uses w8/w9 with post modify, w9+w12, or none.
// - y prefetch uses w10/w11 with post modify, w11+w12, or none.
// - prefetched data goes to one of w4..w7 by its field.
// - width suffix picks byte, word or double word; shadow separate.
`timescale 1ns/1ps
module opd_operand_decode #(
    parameter int INSN_WIDTH = opd_pkg::INSN_W
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic insn_valid_i,
    input wire logic [INSN_WIDTH-1:0] insn_i,
    input wire logic second_word_i,
    input wire logic dsp_class_i,
    input wire logic flag_we_i,
    input wire opd_pkg::opd_cpu_flags_s flag_in_i,
    input wire logic dsp_flag_we_i,
    input wire opd_pkg::opd_dsp_flags_s dsp_flag_in_i,
    output logic dec_valid_o,
    output logic [7:0] insn_type_o,
    output logic is_nop_o,
    output opd_pkg::opd_size_e size_o,
    output logic shadow_sel_o,
    output opd_pkg::opd_waddr_s src_reg_o,
    output opd_pkg::opd_waddr_s dest_reg_o,
    output logic [3:0] base_reg_o,
    output logic [3:0] bit_index_field_o,
    output logic [15:0] bit_mask_o,
    output logic [12:0] file_addr_o,
    output logic [3:0] implied_file_working_reg_o,
    output logic [9:0] ten_bit_unsigned_const_o,
    output logic ten_bit_range_err_o,
    output logic [22:0] program_address_const_o,
    output logic [15:0] unsigned_const_o,
    output logic signed [15:0] signed_six_bit_const_o,
    output logic signed [15:0] signed_ten_bit_const_o,
    output logic signed [15:0] signed_sixteen_bit_const_o,
    output logic [3:0] divide_dividend_o,
    output logic [3:0] divide_divisor_o,
    output logic [3:0] square_operand_pair_o,
    output logic square_ok_o,
    output opd_pkg::opd_dsp_s dsp_o,
    output opd_pkg::opd_prefetch_s x_prefetch_addr_o,
    output opd_pkg::opd_prefetch_s y_prefetch_addr_o,
    output opd_pkg::opd_cpu_flags_s cpu_flags_o,
    output opd_pkg::opd_dsp_flags_s dsp_flags_o
);
    // field layout only fits the 24-bit word
    if (INSN_WIDTH != opd_pkg::INSN_W) begin : g_width_check
        $error("instruction width must be 24");
    end

    logic [23:0] word;
    logic word_second;
    logic word_dsp;
    logic [15:0] opnd;
    logic [7:0] wtype;
    opd_pkg::opd_prefetch_s next_x_pf;
    opd_pkg::opd_prefetch_s next_y_pf;

    // 3-bit addressing mode field; dsp form adds the indexed mode
    function automatic opd_pkg::opd_amode_e amode_of(input logic [2:0] m,
                                                     input logic dsp);
        case (m)
            3'h0: amode_of = opd_pkg::OPD_AM_DIRECT;
            3'h1: amode_of = opd_pkg::OPD_AM_INDIRECT;
            3'h2: amode_of = opd_pkg::OPD_AM_POST_DEC;
            3'h3: amode_of = opd_pkg::OPD_AM_POST_INC;
            3'h4: amode_of = opd_pkg::OPD_AM_PRE_DEC;
            3'h5: amode_of = opd_pkg::OPD_AM_PRE_INC;
            3'h6: amode_of = dsp ? opd_pkg::OPD_AM_INDEXED : opd_pkg::OPD_AM_BAD;
            default: amode_of = opd_pkg::OPD_AM_BAD;
        endcase
    endfunction

    // sign extension to the 16-bit datapath
    function automatic logic signed [15:0] sext(input logic [15:0] v,
                                                input int w);
        logic [15:0] m;
        m = 16'hFFFF << w;
        sext = v[w-1] ? (v | m) : (v & ~m);
    endfunction

    // capture stage; decoded fields stay until the next valid word
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            word <= 24'h000000;
            word_second <= 1'b0;
            word_dsp <= 1'b0;
            dec_valid_o <= 1'b0;
        end else begin
            dec_valid_o <= insn_valid_i;
            if (insn_valid_i) begin
                word <= insn_i[23:0];
                word_second <= second_word_i;
                word_dsp <= dsp_class_i;
            end
        end
    end

    assign wtype = word[opd_pkg::TYPE_LSB +: opd_pkg::TYPE_W];
    assign opnd = word[15:0];

    opd_prefetch_decode u_x_pf (
        .code_i(opnd[opd_pkg::X_PF_LSB +: 4]),
        .dest_i(opnd[opd_pkg::XD_LSB +: 2]),
        .reg_lo_i(opd_pkg::REG_W8),
        .reg_hi_i(opd_pkg::REG_W9),
        .pf_o(next_x_pf)
    );

    opd_prefetch_decode u_y_pf (
        .code_i(opnd[opd_pkg::Y_PF_LSB +: 4]),
        .dest_i(opnd[opd_pkg::YD_LSB +: 2]),
        .reg_lo_i(opd_pkg::REG_W10),
        .reg_hi_i(opd_pkg::REG_W11),
        .pf_o(next_y_pf)
    );

    // a lone second word forces nop and clears operand and prefetch valids; dsp write-back kind is not gated
    always_comb begin
        is_nop_o = word_second && (wtype == opd_pkg::SECOND_WORD_TYPE);
        insn_type_o = is_nop_o ? opd_pkg::NOP_TYPE : wtype;
    end

    always_comb begin
        case (opnd[opd_pkg::WIDTH_LSB +: 2])
            2'h0: size_o = opd_pkg::OPD_SZ_WORD;
            2'h1: size_o = opd_pkg::OPD_SZ_BYTE;
            2'h2: size_o = opd_pkg::OPD_SZ_DWORD;
            default: size_o = opd_pkg::OPD_SZ_BAD;
        endcase
        shadow_sel_o = opnd[opd_pkg::SHADOW_BIT];
    end

    always_comb begin
        base_reg_o = opnd[opd_pkg::BASE_REG_LSB +: 4];
        src_reg_o.valid = !is_nop_o;
        src_reg_o.reg_sel = opnd[opd_pkg::SRC_REG_LSB +: 4];
        src_reg_o.base_sel = base_reg_o;
        src_reg_o.mode = amode_of(opnd[opd_pkg::SRC_MODE_LSB +: 3], word_dsp);
        dest_reg_o.valid = !is_nop_o;
        dest_reg_o.reg_sel = opnd[opd_pkg::DST_REG_LSB +: 4];
        dest_reg_o.base_sel = base_reg_o;
        dest_reg_o.mode = amode_of(opnd[opd_pkg::DST_MODE_LSB +: 3],
                                   word_dsp);
    end

    always_comb begin
        bit_index_field_o = opnd[opd_pkg::BIT_INDEX_LSB +: 4];
        bit_mask_o = 16'h0001 << bit_index_field_o;
        file_addr_o = opnd[opd_pkg::FILE_ADDR_W-1:0] & opd_pkg::FILE_ADDR_MAX;
        implied_file_working_reg_o = opd_pkg::REG_W0;
    end

    // byte mode clamps to 255 and flags the overrange literal
    always_comb begin
        ten_bit_range_err_o = 1'b0;
        ten_bit_unsigned_const_o = opnd[9:0];
        if (size_o == opd_pkg::OPD_SZ_BYTE && opnd[9:0] > opd_pkg::BYTE_LIT_MAX) begin
            ten_bit_range_err_o = 1'b1;
            ten_bit_unsigned_const_o = opd_pkg::BYTE_LIT_MAX;
        end
    end

    always_comb begin
        program_address_const_o = {word[22:1], 1'b0};
        unsigned_const_o = opnd;
        signed_six_bit_const_o = sext(opnd, 6);
        signed_ten_bit_const_o = sext(opnd, 10);
        signed_sixteen_bit_const_o = opnd;
    end

    // divide operands are register numbers only, never an address mode
    always_comb begin
        divide_dividend_o = opnd[opd_pkg::DST_REG_LSB +: 4];
        divide_divisor_o = opnd[opd_pkg::SRC_REG_LSB +: 4];
        square_operand_pair_o = opd_pkg::REG_W4 + {2'h0, opnd[1:0]};
        square_ok_o = !is_nop_o;
    end

    // mul pair code 0..5 gives the six distinct pairs; 6,7 refused
    always_comb begin
        dsp_o = '0;
        dsp_o.acc_sel_b = opnd[opd_pkg::ACC_SEL_BIT];
        dsp_o.mul_ok = !is_nop_o;
        case ({opnd[1:0], word[16]})
            3'h0: begin dsp_o.mul_a = 4'h4; dsp_o.mul_b = 4'h5; end
            3'h1: begin dsp_o.mul_a = 4'h4; dsp_o.mul_b = 4'h6; end
            3'h2: begin dsp_o.mul_a = 4'h4; dsp_o.mul_b = 4'h7; end
            3'h3: begin dsp_o.mul_a = 4'h5; dsp_o.mul_b = 4'h6; end
            3'h4: begin dsp_o.mul_a = 4'h5; dsp_o.mul_b = 4'h7; end
            3'h5: begin dsp_o.mul_a = 4'h6; dsp_o.mul_b = 4'h7; end
            default: begin
                dsp_o.mul_a = opd_pkg::REG_W4;
                dsp_o.mul_b = opd_pkg::REG_W4;
                dsp_o.mul_ok = 1'b0;
            end
        endcase
        dsp_o.wb_reg = opd_pkg::REG_W13;
        if (!opnd[opd_pkg::WB_EN_BIT]) begin
            dsp_o.wb_kind = opd_pkg::OPD_WB_NONE;
        end else if (opnd[opd_pkg::WB_DEST_BIT]) begin
            dsp_o.wb_kind = opd_pkg::OPD_WB_POST_INC2;
            dsp_o.wb_post_mod = opd_pkg::WB_POST_INC;
        end else begin
            dsp_o.wb_kind = opd_pkg::OPD_WB_DIRECT;
        end
        x_prefetch_addr_o = next_x_pf;
        y_prefetch_addr_o = next_y_pf;
        if (is_nop_o) begin
            x_prefetch_addr_o.valid = 1'b0;
            y_prefetch_addr_o.valid = 1'b0;
        end
    end

    // flags hold between updates; datapath owns the update equations
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            cpu_flags_o <= '0;
        end else if (flag_we_i) begin
            cpu_flags_o <= flag_in_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            dsp_flags_o <= '0;
        end else if (dsp_flag_we_i) begin
            dsp_flags_o <= dsp_flag_in_i;
        end
    end
endmodule // opd_operand_decode

// >>> opd_operand_decode_monitor.sv
/*
 checker for the operand decoder: port-level assertions.
 assumes binding into opd_operand_decode, one clock, sync active-low reset.
*/
`timescale 1ns/1ps
module opd_operand_decode_monitor #(
    parameter int INSN_WIDTH = opd_pkg::INSN_W
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic insn_valid_i,
    input wire logic [INSN_WIDTH-1:0] insn_i,
    input wire logic second_word_i,
    input wire logic flag_we_i,
    input wire opd_pkg::opd_cpu_flags_s flag_in_i,
    input wire logic dsp_flag_we_i,
    input wire opd_pkg::opd_dsp_flags_s dsp_flag_in_i,
    input wire logic dec_valid_o,
    input wire logic [7:0] insn_type_o,
    input wire logic is_nop_o,
    input wire opd_pkg::opd_size_e size_o,
    input wire logic [3:0] bit_index_field_o,
    input wire logic [15:0] bit_mask_o,
    input wire logic [12:0] file_addr_o,
    input wire logic [9:0] ten_bit_unsigned_const_o,
    input wire logic [22:0] program_address_const_o,
    input wire logic [3:0] square_operand_pair_o,
    input wire opd_pkg::opd_dsp_s dsp_o,
    input wire opd_pkg::opd_cpu_flags_s cpu_flags_o,
    input wire opd_pkg::opd_dsp_flags_s dsp_flags_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    dec_latency_a: assert property (insn_valid_i |=> dec_valid_o ##1 (!dec_valid_o || $past(insn_valid_i)))
        else $error("decode valid latency wrong");
    type_field_a: assert property (insn_valid_i && !second_word_i |=> insn_type_o == 8'($past(insn_i) >> 16))
        else $error("type field wrong");
    lone_nop_a: assert property (insn_valid_i && second_word_i && insn_i[23:16] == 8'h00 |=> is_nop_o && insn_type_o == 8'h00)
        else $error("lone second word not nop");
    bit_mask_a: assert property (dec_valid_o |-> bit_mask_o == (16'h0001 << bit_index_field_o) && bit_index_field_o == 4'($past(insn_i) >> 12))
        else $error("bit mask wrong");
    file_addr_a: assert property (dec_valid_o |-> file_addr_o == 13'($past(insn_i)))
        else $error("file address wrong");
    prog_lsb_a: assert property (dec_valid_o |-> program_address_const_o == (23'($past(insn_i)) & 23'h7FFFFE))
        else $error("program address wrong");
    byte_clamp_a: assert property (dec_valid_o && size_o == opd_pkg::OPD_SZ_BYTE |-> ten_bit_unsigned_const_o <= opd_pkg::BYTE_LIT_MAX)
        else $error("byte literal over range");
    cpu_flag_a: assert property (flag_we_i |=> cpu_flags_o == $past(flag_in_i) ##1 ($past(flag_we_i) || $stable(cpu_flags_o)))
        else $error("cpu flags wrong");
    dsp_flag_a: assert property (dsp_flag_we_i |=> dsp_flags_o == $past(dsp_flag_in_i))
        else $error("dsp flags wrong");
    square_pair_a: assert property (dec_valid_o && !is_nop_o |-> square_operand_pair_o inside {[4'h4:4'h7]})
        else $error("square pair out of set");
    mul_pair_a: assert property (dsp_o.mul_ok |-> dsp_o.mul_a >= 4'h4 && dsp_o.mul_b <= 4'h7 && dsp_o.mul_a < dsp_o.mul_b)
        else $error("multiply pair out of set");
endmodule // opd_operand_decode_monitor

bind opd_operand_decode opd_operand_decode_monitor #(.INSN_WIDTH(INSN_WIDTH)) i_opd_operand_decode_monitor (
    .clk_sys_i, .rstn_i, .insn_valid_i, .insn_i, .second_word_i, .flag_we_i, .flag_in_i,
    .dsp_flag_we_i, .dsp_flag_in_i, .dec_valid_o, .insn_type_o, .is_nop_o, .size_o,
    .bit_index_field_o, .bit_mask_o, .file_addr_o, .ten_bit_unsigned_const_o,
    .program_address_const_o, .square_operand_pair_o, .dsp_o, .cpu_flags_o, .dsp_flags_o);

// >>> opd_fetch_model.sv
/*
 fetch stage model: hands instruction words to the decoder.
 assumes the bench calls send and idle; drives after the falling edge.
*/
`timescale 1ns/1ps
module opd_fetch_model (
    input wire logic clk_sys_i,
    output logic insn_valid_o,
    output logic [23:0] insn_o,
    output logic second_word_o,
    output logic dsp_class_o
);
    initial begin
        insn_valid_o = 1'b0;
        insn_o = 24'h000000;
        second_word_o = 1'b0;
        dsp_class_o = 1'b0;
    end
    task automatic send(input logic [23:0] w, input logic sec, input logic dsp);
        @(negedge clk_sys_i);
        insn_valid_o <= 1'b1;
        insn_o <= w;
        second_word_o <= sec;
        dsp_class_o <= dsp;
    endtask
    // word is not held between sends: decoder must keep its own copy
    task automatic idle();
        @(negedge clk_sys_i);
        insn_valid_o <= 1'b0;
        insn_o <= ~insn_o;
        second_word_o <= ~second_word_o;
        dsp_class_o <= ~dsp_class_o;
    endtask
endmodule // opd_fetch_model

// >>> testbench.sv
/*
 testbench for the operand decoder: sweep, boundary and random words, flags, reset.
 assumes the fetch model and the bound monitor are compiled alongside.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) chk(nm, (g) === (e), 64'(e), 64'(g))
module testbench;
    logic clk_sys_i, rstn_i, insn_valid_i, second_word_i, dsp_class_i, flag_we_i, dsp_flag_we_i;
    logic [23:0] insn_i;
    opd_pkg::opd_cpu_flags_s flag_in_i, cpu_flags_o;
    opd_pkg::opd_dsp_flags_s dsp_flag_in_i, dsp_flags_o;
    logic dec_valid_o, is_nop_o, shadow_sel_o, ten_bit_range_err_o, square_ok_o;
    logic [7:0] insn_type_o;
    opd_pkg::opd_size_e size_o;
    opd_pkg::opd_waddr_s src_reg_o, dest_reg_o;
    logic [3:0] base_reg_o, bit_index_field_o, implied_file_working_reg_o;
    logic [3:0] divide_dividend_o, divide_divisor_o, square_operand_pair_o;
    logic [15:0] bit_mask_o, unsigned_const_o;
    logic [12:0] file_addr_o;
    logic [9:0] ten_bit_unsigned_const_o;
    logic [22:0] program_address_const_o;
    logic signed [15:0] signed_six_bit_const_o, signed_ten_bit_const_o, signed_sixteen_bit_const_o;
    opd_pkg::opd_dsp_s dsp_o;
    opd_pkg::opd_prefetch_s x_prefetch_addr_o, y_prefetch_addr_o;
    int err_total = 0;
    int n_tests = 0;
    integer seed = 90892;
    logic [25:0] notes[$];
    logic [25:0] nt;
    logic [2:0] am_tab [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h5, 3'h4, 3'h6, 3'h7};
    logic [3:0] pm [7] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'hE, 4'hC, 4'hA};
    logic [7:0] mt [6] = '{8'h45, 8'h46, 8'h47, 8'h56, 8'h57, 8'h67};
    logic [23:0] bnd [5] = '{24'h3040FF, 24'h304100, 24'h3003FF, 24'h30E3FF, 24'h0000AA};
    logic [23:0] w;
    logic [8:0] fl;
    logic [3:0] dq;
    logic s;

    opd_operand_decode i_opd_operand_decode (.clk_sys_i, .rstn_i, .insn_valid_i, .insn_i,
        .second_word_i, .dsp_class_i, .flag_we_i, .flag_in_i, .dsp_flag_we_i, .dsp_flag_in_i,
        .dec_valid_o, .insn_type_o, .is_nop_o, .size_o, .shadow_sel_o, .src_reg_o, .dest_reg_o,
        .base_reg_o, .bit_index_field_o, .bit_mask_o, .file_addr_o, .implied_file_working_reg_o,
        .ten_bit_unsigned_const_o, .ten_bit_range_err_o, .program_address_const_o,
        .unsigned_const_o, .signed_six_bit_const_o, .signed_ten_bit_const_o,
        .signed_sixteen_bit_const_o, .divide_dividend_o, .divide_divisor_o,
        .square_operand_pair_o, .square_ok_o, .dsp_o, .x_prefetch_addr_o, .y_prefetch_addr_o,
        .cpu_flags_o, .dsp_flags_o);
    opd_fetch_model i_opd_fetch_model (.clk_sys_i, .insn_valid_o(insn_valid_i), .insn_o(insn_i),
        .second_word_o(second_word_i), .dsp_class_o(dsp_class_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input string nm, input bit ok, input logic [63:0] e, input logic [63:0] g);
        n_tests++;
        if (!ok) begin
            err_total++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic put(input logic [23:0] v, input logic sec, input logic dsp);
        i_opd_fetch_model.send(v, sec, dsp);
        notes.push_back({dsp, sec, v});
    endtask

    task automatic chk_pf(input string nm, input opd_pkg::opd_prefetch_s p, input logic [3:0] c,
        input logic [1:0] d, input logic [3:0] lo, input logic nop);
        `CHK(nm, !nop && c != 4'hF, p.valid);
        if (!nop && c != 4'hF) begin
            `CHK(nm, (c < 4'h7) ? lo : lo + 4'h1, p.reg_sel);
            `CHK(nm, (c < 4'hE) ? pm[c % 7] : 4'h0, 4'(p.post_mod));
            `CHK(nm, c == 4'hE, p.use_offset);
            `CHK(nm, 4'h4 + 4'(d), p.dest_sel);
        end
    endtask

    task automatic check_word(input logic [23:0] v, input logic sec, input logic dsp);
        logic nop;
        logic big;
        logic [2:0] mi;
        nop = sec && v[23:16] == 8'h00;
        big = v[15:14] == 2'b01 && v[9:0] > 10'h0FF;
        mi = {v[1:0], v[16]};
        `CHK("nop", nop, is_nop_o);
        `CHK("type", nop ? 8'h00 : v[23:16], insn_type_o);
        chk_pf("x prefetch", x_prefetch_addr_o, v[5:2], v[11:10], opd_pkg::REG_W8, nop);
        chk_pf("y prefetch", y_prefetch_addr_o, v[9:6], v[13:12], opd_pkg::REG_W10, nop);
        `CHK("square ok", !nop, square_ok_o);
        `CHK("src valid", !nop, src_reg_o.valid);
        `CHK("dest valid", !nop, dest_reg_o.valid);
        if (!nop) begin
            `CHK("size", v[15:14], 2'(size_o));
            `CHK("shadow", v[13], shadow_sel_o);
            `CHK("src reg", v[3:0], src_reg_o.reg_sel);
            `CHK("dest reg", v[10:7], dest_reg_o.reg_sel);
            `CHK("base reg", v[14:11], base_reg_o);
            `CHK("src mode", (v[6:4] == 3'h6 && !dsp) ? 3'h7 : am_tab[v[6:4]], 3'(src_reg_o.mode));
            `CHK("dest mode", (v[13:11] == 3'h6 && !dsp) ? 3'h7 : am_tab[v[13:11]],
                3'(dest_reg_o.mode));
            `CHK("bit mask", 16'h0001 << v[15:12], bit_mask_o);
            `CHK("bit index", v[15:12], bit_index_field_o);
            `CHK("ten_bit_unsigned_const", big ? 10'h0FF : v[9:0], ten_bit_unsigned_const_o);
            `CHK("ten_bit_unsigned_const err", big, ten_bit_range_err_o);
            `CHK("prog addr", {v[22:1], 1'b0}, program_address_const_o);
            `CHK("ulit", v[15:0], unsigned_const_o);
            `CHK("signed_six_bit_const", {{10{v[5]}}, v[5:0]}, signed_six_bit_const_o);
            `CHK("signed_ten_bit_const", {{6{v[9]}}, v[9:0]}, signed_ten_bit_const_o);
            `CHK("slit16", v[15:0], signed_sixteen_bit_const_o);
            `CHK("file addr", v[12:0], file_addr_o);
            `CHK("implied_file_working_reg", opd_pkg::REG_W0, implied_file_working_reg_o);
            `CHK("divide", {v[10:7], v[3:0]}, {divide_dividend_o, divide_divisor_o});
            `CHK("square", 4'h4 + 4'(v[1:0]), square_operand_pair_o);
            `CHK("acc b", v[15], dsp_o.acc_sel_b);
            `CHK("mul ok", mi < 3'h6, dsp_o.mul_ok);
            if (mi < 3'h6) `CHK("mul pair", mt[mi], {dsp_o.mul_a, dsp_o.mul_b});
            `CHK("wb kind", !v[13] ? 2'h0 : (v[14] ? 2'h2 : 2'h1), 2'(dsp_o.wb_kind));
            if (v[13]) `CHK("wb reg", opd_pkg::REG_W13, dsp_o.wb_reg);
            if (v[13] && v[14]) `CHK("wb step", 5'h02, dsp_o.wb_post_mod);
        end
    endtask

    // outputs are settled by the falling edge
    always @(negedge clk_sys_i) begin
        if (dec_valid_o === 1'b1) begin
            if (notes.size() == 0) `CHK("note", 1'b1, 1'b0);
            else begin
                nt = notes.pop_front();
                check_word(nt[23:0], nt[24], nt[25]);
            end
        end
    end

    initial begin
        #100us;
        err_total++;
        complete_run();
    end

    initial begin
        rstn_i = 1'b0;
        flag_we_i = 1'b0;
        dsp_flag_we_i = 1'b0;
        flag_in_i = 5'h00;
        dsp_flag_in_i = 4'h0;
        dq = 4'h0;
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i) rstn_i = 1'b1;
        `CHK("flags rst", 9'h000, {cpu_flags_o, dsp_flags_o});
        for (int i = 0; i < 16; i++) put({8'h10 + 8'(i), 16'(i * 16'h1111)}, 1'b0, i[0]);
        foreach (bnd[k]) put(bnd[k], 1'b0, 1'b1);
        put(24'h00BEEF, 1'b1, 1'b0);
        for (int i = 0; i < 300; i++) begin
            w = 24'($random(seed));
            s = ($random(seed) & 3) == 0;
            if (s) w[23:16] = 8'h00;
            put(w, s, w[20]);
            if (w[19:18] == 2'b00) i_opd_fetch_model.idle();
        end
        i_opd_fetch_model.idle();
        for (int i = 0; i < 20; i++) begin
            @(negedge clk_sys_i);
            fl = 9'($random(seed));
            flag_we_i <= 1'b1;
            dsp_flag_we_i <= i[0];
            flag_in_i <= fl[8:4];
            dsp_flag_in_i <= fl[3:0];
            if (i[0]) dq = fl[3:0];
            @(negedge clk_sys_i);
            flag_we_i <= 1'b0;
            dsp_flag_we_i <= 1'b0;
            `CHK("cpu flags", fl[8:4], cpu_flags_o);
            `CHK("dsp flags", dq, dsp_flags_o);
        end
        // word offered on the reset edge must be dropped
        i_opd_fetch_model.send(24'h123456, 1'b0, 1'b0);
        rstn_i <= 1'b0;
        i_opd_fetch_model.idle();
        @(negedge clk_sys_i) rstn_i <= 1'b1;
        `CHK("reset", 10'h000, {dec_valid_o, cpu_flags_o, dsp_flags_o});
        put(24'h7FE3A5, 1'b0, 1'b1);
        i_opd_fetch_model.idle();
        repeat (3) @(negedge clk_sys_i);
        `CHK("notes left", 0, notes.size());
        complete_run();
    end
endmodule // testbench
